// File: design/wdog_pkg.sv
package wdog_pkg;

   // -------------------------------------------------------------------
   // Timebase
   // -------------------------------------------------------------------
   localparam int CLK_PERIOD_PS = 4000;            // 250 MHz core clock
   localparam int MS_IN_PS = 1000000000;           // One millisecond in ps
   localparam int MS_TICK_CYCLES = MS_IN_PS / CLK_PERIOD_PS;
   localparam int TICK_W = 18;                     // Holds MS_TICK_CYCLES - 1

   // -------------------------------------------------------------------
   // Reset cycle length
   // -------------------------------------------------------------------
   localparam int RST_TIMEOUT_S = 135;             // Reset timeout as printed, seconds
   localparam int MS_PER_S = 1000;
   localparam int RST_TIMEOUT_MS = RST_TIMEOUT_S * MS_PER_S;
   localparam int RST_W = 18;                      // Holds RST_TIMEOUT_MS - 1

   // -------------------------------------------------------------------
   // Kick timeout selection
   // -------------------------------------------------------------------
   localparam int PERIOD_W = 12;                   // Holds 2048
   localparam logic [PERIOD_W-1:0] PERIOD_BASE_MS = 12'h010;  // 16 ms
   localparam int EXP_W = 4;
   localparam logic [EXP_W-1:0] EXP_DISABLED = 4'h8;          // Both straps at supply
   localparam logic [EXP_W-1:0] HI_WEIGHT = 4'h3;             // Weight of the high strap

   // Strap pin codes as delivered by the three-level input cell
   localparam logic [1:0] STRAP_GND = 2'h0;
   localparam logic [1:0] STRAP_MID = 2'h1;
   localparam logic [1:0] STRAP_SUPPLY = 2'h2;
   localparam logic [1:0] STRAP_OPEN = 2'h3;

   // Decoded strap levels
   localparam logic [1:0] LVL_GND = 2'h0;
   localparam logic [1:0] LVL_MID = 2'h1;
   localparam logic [1:0] LVL_SUPPLY = 2'h2;

   // Constant level driven by the open-drain fault pin when enabled
   localparam logic FAULT_PIN_LOW = 1'b0;

   typedef enum logic [0:0]
   {
      ST_RUN = 1'b0,
      ST_RESET = 1'b1
   } sup_state_t;

endpackage

// File: design/kick_if.sv
`timescale 1ns/10ps

// Carries the detected kick edge from the input stage to the supervisor
interface kick_if;
   logic kick_rise;

   modport src
   (
      output kick_rise
   );

   modport dst
   (
      input kick_rise
   );
endinterface

// File: design/kick_edge_detect.sv
`timescale 1ns/10ps

module kick_edge_detect
(
   input wire logic clk,
   input wire logic rst_b,
   input wire logic ce,
   input wire logic kick_raw,
   kick_if.src ev
);

   logic meta_q;
   logic sync_q;
   logic prev_q;

   // ------------------------------------------------------------------
   // Synchroniser and edge history
   // ------------------------------------------------------------------
   // Only sync_q reads meta_q; the edge logic looks at settled samples
   always_ff @(posedge clk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         meta_q <= 1'b0;
         sync_q <= 1'b0;
         prev_q <= 1'b0;
      end
      else if (ce)
      begin
         meta_q <= kick_raw;
         sync_q <= meta_q;
         prev_q <= sync_q;
      end
   end

   // Low then high on consecutive settled samples
   assign ev.kick_rise = sync_q & ~prev_q;

endmodule

// File: design/pin_strapped_watchdog_supervisor.sv
// Overview of operation
// - Host kicks with a rising edge before timeout; each edge restarts the count.
// - Missed kick starts a reset cycle and asserts the fault output.
// - When the reset releases, watchdog state clears and a fresh count begins.
// - Fault stays asserted through reset; only a later kick edge or RST_B clears it.
// - Fault output powers up inactive, released high, until a timeout.
// - Timeout is 16 ms times two to the (lo level + 3 x hi level).
// - Each select strap decodes to ground, mid or supply; nine combinations.
// - Both straps at supply disable the watchdog completely, for test use.
// - Watchdog timer is held inactive while the supervisor reset is asserted.
// - An unconnected select strap counts as the mid level.
// - Real timeout may deviate about -30 to +38 percent from typical.
// - A reset cycle holds the reset output for the reset timeout, then releases.
`timescale 1ns/10ps

module pin_strapped_watchdog_supervisor
#(
   parameter int MS_TICK_CYCLES = wdog_pkg::MS_TICK_CYCLES,
   parameter int RST_TIMEOUT_MS = wdog_pkg::RST_TIMEOUT_MS
)
(
   input wire logic CLK,
   input wire logic RST_B,
   input wire logic CE,
   input wire logic KICK_IN,
   input wire logic [1:0] PERIOD_SEL_LO,
   input wire logic [1:0] PERIOD_SEL_HI,
   input wire logic SUPPLY_LOW,
   input wire logic FAULT_FLAG_OUT_I,
   output logic SUP_RST_OUT,
   output logic FAULT_FLAG_OUT_O,
   output logic FAULT_FLAG_OUT_OE,
   output logic WD_EXPIRE
);

   // ------------------------------------------------------------------
   // Declarations
   // ------------------------------------------------------------------
   localparam int TICK_W = wdog_pkg::TICK_W;
   localparam int RST_W = wdog_pkg::RST_W;
   localparam int PERIOD_W = wdog_pkg::PERIOD_W;
   localparam int EXP_W = wdog_pkg::EXP_W;

   kick_if kick ();

   wdog_pkg::sup_state_t state_q;
   logic [TICK_W-1:0] tick_cnt_q;
   logic tick_q;
   logic [RST_W-1:0] rst_ms_q;
   logic [PERIOD_W-1:0] wd_ms_q;
   logic [PERIOD_W-1:0] period_q;
   logic wd_off_q;
   logic sup_rst_q;
   logic fault_q;
   logic pin_o_q;
   logic expire_q;
   logic pin_seen_q;
   logic [1:0] lvl_lo;
   logic [1:0] lvl_hi;
   logic [EXP_W-1:0] exp_d;
   logic expire;
   logic rst_done;

   // ------------------------------------------------------------------
   // Strap decoding
   // ------------------------------------------------------------------
   // Three-level strap cell code to level; a floating pin is biased mid
   function automatic logic [1:0] strap_level(input logic [1:0] code);
      logic [1:0] lvl;
      lvl = wdog_pkg::LVL_MID;
      if (code == wdog_pkg::STRAP_GND)
      begin
         lvl = wdog_pkg::LVL_GND;
      end
      else if (code == wdog_pkg::STRAP_SUPPLY)
      begin
         lvl = wdog_pkg::LVL_SUPPLY;
      end
      else if (code == wdog_pkg::STRAP_OPEN)
      begin
         lvl = wdog_pkg::LVL_MID;
      end
      return lvl;
   endfunction

   assign lvl_lo = strap_level(PERIOD_SEL_LO);
   assign lvl_hi = strap_level(PERIOD_SEL_HI);

   // Exponent lo + 3 x hi; both at supply lands on the disable code
   assign exp_d = EXP_W'(lvl_lo) + EXP_W'(lvl_hi) * wdog_pkg::HI_WEIGHT;

   // Period is registered so the shift never sits in the compare path.
   // Straps may move at any time; a new value takes effect one cycle later.
   always_ff @(posedge CLK or negedge RST_B)
   begin
      if (!RST_B)
      begin
         period_q <= wdog_pkg::PERIOD_BASE_MS;
         wd_off_q <= 1'b0;
      end
      else if (CE)
      begin
         period_q <= wdog_pkg::PERIOD_BASE_MS << exp_d;
         wd_off_q <= (exp_d == wdog_pkg::EXP_DISABLED);
      end
   end

   // ------------------------------------------------------------------
   // Kick input stage
   // ------------------------------------------------------------------
   kick_edge_detect u_kick
   (
      .clk(CLK),
      .rst_b(RST_B),
      .ce(CE),
      .kick_raw(KICK_IN),
      .ev(kick.src)
   );

   // ------------------------------------------------------------------
   // Millisecond timebase
   // ------------------------------------------------------------------
   // Free running; the kick count is not phase aligned to it, so the first
   // millisecond after a restart may be short by up to one tick. That error
   // is far inside the allowed band on the timeout.
   always_ff @(posedge CLK or negedge RST_B)
   begin
      if (!RST_B)
      begin
         tick_cnt_q <= '0;
         tick_q <= 1'b0;
      end
      else if (CE)
      begin
         if (tick_cnt_q == TICK_W'(MS_TICK_CYCLES - 1))
         begin
            tick_cnt_q <= '0;
            tick_q <= 1'b1;
         end
         else
         begin
            tick_cnt_q <= tick_cnt_q + TICK_W'(1);
            tick_q <= 1'b0;
         end
      end
   end

   // ------------------------------------------------------------------
   // Kick timeout counter
   // ------------------------------------------------------------------
   // Expiry needs a running watchdog, an enabled setting and no kick edge in
   // the same cycle; an edge arriving exactly at the limit still saves the host.
   // The typical period is targeted; the clock accuracy keeps it in the band.
   // At-or-above, so a strap moved below the running count still expires.
   assign expire = (state_q == wdog_pkg::ST_RUN) && !wd_off_q
                   && !kick.kick_rise && (wd_ms_q >= period_q);

   always_ff @(posedge CLK or negedge RST_B)
   begin
      if (!RST_B)
      begin
         wd_ms_q <= '0;
      end
      else if (CE)
      begin
         if (state_q == wdog_pkg::ST_RESET)
         begin
            wd_ms_q <= '0;
         end
         else if (kick.kick_rise || wd_off_q || expire)
         begin
            wd_ms_q <= '0;
         end
         else if (tick_q)
         begin
            wd_ms_q <= wd_ms_q + PERIOD_W'(1);
         end
      end
   end

   // ------------------------------------------------------------------
   // Reset cycle sequencing
   // ------------------------------------------------------------------
   // The release comes on the tick that completes the reset timeout
   assign rst_done = tick_q && !SUPPLY_LOW && (rst_ms_q == RST_W'(RST_TIMEOUT_MS - 1));

   // Power-up begins inside a reset cycle, like a supply-threshold reset
   always_ff @(posedge CLK or negedge RST_B)
   begin
      if (!RST_B)
      begin
         state_q <= wdog_pkg::ST_RESET;
         rst_ms_q <= '0;
         sup_rst_q <= 1'b1;
      end
      else if (CE)
      begin
         case (state_q)
            wdog_pkg::ST_RUN:
            begin
               rst_ms_q <= '0;
               if (SUPPLY_LOW || expire)
               begin
                  state_q <= wdog_pkg::ST_RESET;
                  sup_rst_q <= 1'b1;
               end
            end
            wdog_pkg::ST_RESET:
            begin
               if (SUPPLY_LOW)
               begin
                  rst_ms_q <= '0;   // Low supply keeps restarting the cycle
               end
               else if (rst_done)
               begin
                  state_q <= wdog_pkg::ST_RUN;
                  sup_rst_q <= 1'b0;
                  rst_ms_q <= '0;
               end
               else if (tick_q)
               begin
                  rst_ms_q <= rst_ms_q + RST_W'(1);
               end
            end
            default:
            begin
               state_q <= wdog_pkg::ST_RESET;
               sup_rst_q <= 1'b1;
            end
         endcase
      end
   end

   // ------------------------------------------------------------------
   // Fault flag
   // ------------------------------------------------------------------
   // Sticky: it outlives the reset cycle so a status LED or safety latch
   // still sees the failure after the host comes back. Expiry and a kick edge
   // never meet in one cycle, so set and clear cannot collide.
   always_ff @(posedge CLK or negedge RST_B)
   begin
      if (!RST_B)
      begin
         fault_q <= 1'b0;
      end
      else if (CE)
      begin
         if (expire)
         begin
            fault_q <= 1'b1;
         end
         else if (kick.kick_rise)
         begin
            fault_q <= 1'b0;
         end
      end
   end

   // ------------------------------------------------------------------
   // Expiry pulse and open-drain pin data
   // ------------------------------------------------------------------
   // The pin readback is only captured for debug visibility of the wire
   always_ff @(posedge CLK or negedge RST_B)
   begin
      if (!RST_B)
      begin
         expire_q <= 1'b0;
         pin_o_q <= wdog_pkg::FAULT_PIN_LOW;
         pin_seen_q <= 1'b0;
      end
      else if (CE)
      begin
         expire_q <= expire;
         pin_o_q <= wdog_pkg::FAULT_PIN_LOW;
         pin_seen_q <= FAULT_FLAG_OUT_I;
      end
   end

   // ------------------------------------------------------------------
   // Outputs
   // ------------------------------------------------------------------
   assign SUP_RST_OUT = sup_rst_q;
   assign FAULT_FLAG_OUT_O = pin_o_q;
   assign FAULT_FLAG_OUT_OE = fault_q;
   assign WD_EXPIRE = expire_q;

endmodule

// File: sim/wdog_sup_checker.sv
`timescale 1ns/10ps
// ----------------------------------------
// Port checker for the watchdog supervisor
// ----------------------------------------
module wdog_sup_checker
#(
   parameter int MS_TICK_CYCLES = 4,
   parameter int RST_TIMEOUT_MS = 3
)
(
   input wire logic CLK,
   input wire logic RST_B,
   input wire logic CE,
   input wire logic KICK_IN,
   input wire logic [1:0] PERIOD_SEL_LO,
   input wire logic [1:0] PERIOD_SEL_HI,
   input wire logic SUPPLY_LOW,
   input wire logic SUP_RST_OUT,
   input wire logic FAULT_FLAG_OUT_O,
   input wire logic FAULT_FLAG_OUT_OE,
   input wire logic WD_EXPIRE
);
   default clocking cb @(posedge CLK);
   endclocking
   // A frozen block proves nothing, so checks and counters pause with it
   default disable iff (!RST_B || !CE);
   logic [3:0] lv_lo;
   logic [3:0] lv_hi;
   logic [3:0] exp_w;
   logic kick_q;
   int run_q;
   int hold_q;
   // Strap levels, open reads as mid
   assign lv_lo = (PERIOD_SEL_LO == 2'h3) ? 4'h1 : {2'h0, PERIOD_SEL_LO};
   assign lv_hi = (PERIOD_SEL_HI == 2'h3) ? 4'h1 : {2'h0, PERIOD_SEL_HI};
   assign exp_w = lv_lo + 4'h3 * lv_hi;
   // Cycles since restart; a strap change restarts too, so a retimed count is not blamed
   always_ff @(posedge CLK or negedge RST_B)
   begin
      if (!RST_B)
      begin
         kick_q <= 1'b0;
         run_q <= 0;
      end
      else if (CE)
      begin
         kick_q <= KICK_IN;
         if (SUP_RST_OUT || (KICK_IN && !kick_q) || exp_w == 4'h8 || $changed(exp_w))
            run_q <= 0;
         else
            run_q <= run_q + 1;
      end
   end
   // Length of the current reset cycle; a low supply restarts it
   always_ff @(posedge CLK or negedge RST_B)
   begin
      if (!RST_B)
         hold_q <= 0;
      else if (!CE)
         hold_q <= hold_q;
      else if (!SUP_RST_OUT || SUPPLY_LOW)
         hold_q <= 0;
      else
         hold_q <= hold_q + 1;
   end
   a_expire_one_cycle: assert property (WD_EXPIRE |=> !WD_EXPIRE)
      else $error("expire pulse too long");
   a_expire_sets_both: assert property (WD_EXPIRE |-> SUP_RST_OUT && FAULT_FLAG_OUT_OE)
      else $error("expiry without reset and fault");
   a_fault_with_reset: assert property ($rose(FAULT_FLAG_OUT_OE) |-> $rose(SUP_RST_OUT))
      else $error("fault set outside an expiry");
   a_fault_pin_low: assert property (FAULT_FLAG_OUT_OE |-> !FAULT_FLAG_OUT_O)
      else $error("fault pin not driven low");
   a_fault_kick_clear: assert property (
      $fell(FAULT_FLAG_OUT_OE) |-> $past(KICK_IN, 3) && !$past(KICK_IN, 4))
      else $error("fault cleared without kick edge");
   a_disabled_quiet: assert property (
      (PERIOD_SEL_LO == 2'h2 && PERIOD_SEL_HI == 2'h2)[*3] |-> !WD_EXPIRE)
      else $error("expiry while disabled");
   a_no_run_reset: assert property (WD_EXPIRE |-> !$past(SUP_RST_OUT, 2))
      else $error("expiry during reset cycle");
   a_supply_low_reset: assert property (SUPPLY_LOW |=> SUP_RST_OUT)
      else $error("low supply without reset");
   a_expire_bound: assert property (run_q <= (16 << exp_w) * MS_TICK_CYCLES + 8)
      else $error("timeout late");
   a_reset_length: assert property (
      $fell(SUP_RST_OUT) |-> hold_q >= (RST_TIMEOUT_MS - 1) * MS_TICK_CYCLES
         && hold_q <= RST_TIMEOUT_MS * MS_TICK_CYCLES + 3)
      else $error("reset cycle length wrong");
   c_expire: cover property (WD_EXPIRE);
   c_fault_clear: cover property ($fell(FAULT_FLAG_OUT_OE));
   c_reset_end: cover property ($fell(SUP_RST_OUT));
endmodule
bind pin_strapped_watchdog_supervisor wdog_sup_checker
   #(.MS_TICK_CYCLES(MS_TICK_CYCLES), .RST_TIMEOUT_MS(RST_TIMEOUT_MS)) i_chk
   (
      .CLK(CLK),
      .RST_B(RST_B),
      .CE(CE),
      .KICK_IN(KICK_IN),
      .PERIOD_SEL_LO(PERIOD_SEL_LO),
      .PERIOD_SEL_HI(PERIOD_SEL_HI),
      .SUPPLY_LOW(SUPPLY_LOW),
      .SUP_RST_OUT(SUP_RST_OUT),
      .FAULT_FLAG_OUT_O(FAULT_FLAG_OUT_O),
      .FAULT_FLAG_OUT_OE(FAULT_FLAG_OUT_OE),
      .WD_EXPIRE(WD_EXPIRE)
   );

// File: sim/host_kick_model.sv
`timescale 1ns/10ps
// ----------------------------------------
// Host toggling a port pin
// ----------------------------------------
module host_kick_model
(
   input wire logic clk,
   input wire logic en,
   input wire logic [7:0] half_period,
   output logic kick
);
   logic [7:0] cnt_q = 8'h00;
   // Square wave; each rising edge is one kick, pin rests low when idle
   always @(posedge clk)
   begin
      if (!en || cnt_q == half_period - 8'h01)
         cnt_q <= 8'h00;
      else
         cnt_q <= cnt_q + 8'h01;
      kick <= en && (cnt_q == half_period - 8'h01) ? !kick : (en ? kick : 1'b0);
   end
endmodule

// File: sim/pin_strapped_watchdog_supervisor_test.sv
`timescale 1ns/10ps
// ----------------------------------------
// Watchdog supervisor bench
// ----------------------------------------
module pin_strapped_watchdog_supervisor_test;
   localparam int T = 4;
   localparam int R = 3;
   typedef struct {logic [1:0] lo; logic [1:0] hi; int per;} row_t;
   row_t rows [8] = '{'{2'h0, 2'h0, 16}, '{2'h3, 2'h0, 32}, '{2'h2, 2'h0, 64},
      '{2'h0, 2'h1, 128}, '{2'h1, 2'h3, 256}, '{2'h2, 2'h1, 512}, '{2'h0, 2'h2, 1024},
      '{2'h3, 2'h2, 2048}};
   logic clk = 1'b0;
   logic rst_b = 1'b0;
   logic [1:0] sel_lo = 2'h0;
   logic [1:0] sel_hi = 2'h0;
   logic sup_low = 1'b0;
   logic kick_en = 1'b0;
   logic ce = 1'b1;
   logic kick;
   logic fault_wire;
   logic sup_rst;
   logic f_o;
   logic f_oe;
   logic expire;
   int miscompares = 0;
   int n_checks = 0;
   int n_exp = 0;
   int cyc = 0;
   int n;
   int n0;
   always #2 clk = ~clk;
   // Open-drain fault wire with a pull-up
   assign fault_wire = f_oe ? f_o : 1'b1;
   host_kick_model i_host (.clk(clk), .en(kick_en), .half_period(8'h08), .kick(kick));
   pin_strapped_watchdog_supervisor #(.MS_TICK_CYCLES(T), .RST_TIMEOUT_MS(R)) i_dut (.CLK(clk),
      .RST_B(rst_b), .CE(ce), .KICK_IN(kick), .PERIOD_SEL_LO(sel_lo), .PERIOD_SEL_HI(sel_hi),
      .SUPPLY_LOW(sup_low), .FAULT_FLAG_OUT_I(fault_wire), .SUP_RST_OUT(sup_rst),
      .FAULT_FLAG_OUT_O(f_o), .FAULT_FLAG_OUT_OE(f_oe), .WD_EXPIRE(expire));
   // Expiry pulses and hang guard; the rows need about 16400 cycles
   always @(posedge clk)
   begin
      cyc++;
      if (expire === 1'b1)
         n_exp++;
      if (cyc == 40000)
      begin
         miscompares++;
         results();
      end
   end
   task check(input string what, input logic [31:0] seen, input logic [31:0] expv);
      n_checks++;
      if (seen !== expv)
      begin
         $display("[ERR] %s expected %0h seen %0h", what, expv, seen);
         miscompares++;
      end
   endtask
   task wait_rst_end();
      for (int i = 0; i < 40 && sup_rst !== 1'b0; i++)
         @(negedge clk);
      check("reset release", sup_rst, 1'b0);
   endtask
   task results();
      $display("checks %0d miscompares %0d", n_checks, miscompares);
      if (miscompares == 0 && n_checks > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask
   initial
   begin
      repeat (4) @(posedge clk);
      rst_b <= 1'b1;
      // Every period setting, measured from reset release to expiry
      foreach (rows[i])
      begin
         @(posedge clk);
         sel_lo <= rows[i].lo;
         sel_hi <= rows[i].hi;
         wait_rst_end();
         n = 0;
         while (expire !== 1'b1 && n < rows[i].per * T + 20)
         begin
            @(negedge clk);
            n++;
         end
         check("period", n >= (rows[i].per - 1) * T && n <= rows[i].per * T + 4, 1'b1);
         check("fault set", f_oe, 1'b1);
         check("reset set", sup_rst, 1'b1);
         $display("period row %0d done", i);
      end
      // Fault outlives the reset cycle, then a kicking host clears it
      @(posedge clk);
      sel_lo <= 2'h0;
      sel_hi <= 2'h0;
      wait_rst_end();
      check("fault held", fault_wire, 1'b0);
      n0 = n_exp;
      kick_en <= 1'b1;
      repeat (400) @(negedge clk);
      check("kicked expiries", n_exp - n0, 0);
      check("fault cleared", fault_wire, 1'b1);
      $display("kick test done");
      // Both straps at supply
      @(posedge clk);
      kick_en <= 1'b0;
      sel_lo <= 2'h2;
      sel_hi <= 2'h2;
      n0 = n_exp;
      repeat (600) @(negedge clk);
      check("disabled expiries", n_exp - n0, 0);
      check("disabled reset", sup_rst, 1'b0);
      $display("disable test done");
      // Low supply gives a reset cycle without a fault
      @(posedge clk);
      sel_lo <= 2'h0;
      sel_hi <= 2'h0;
      sup_low <= 1'b1;
      repeat (5) @(negedge clk);
      check("supply reset", sup_rst, 1'b1);
      check("supply fault", f_oe, 1'b0);
      @(posedge clk);
      sup_low <= 1'b0;
      wait_rst_end();
      $display("supply test done");
      // Enable low freezes the count; a pause far past the period gives no expiry
      @(posedge clk);
      ce <= 1'b0;
      n0 = n_exp;
      repeat (200) @(negedge clk);
      check("frozen expiries", n_exp - n0, 0);
      check("frozen reset", sup_rst, 1'b0);
      @(posedge clk);
      ce <= 1'b1;
      $display("freeze test done");
      // Hard reset while the fault is set
      n = 0;
      while (expire !== 1'b1 && n < 100)
      begin
         @(negedge clk);
         n++;
      end
      check("fault before reset", f_oe, 1'b1);
      @(posedge clk);
      rst_b <= 1'b0;
      repeat (4) @(negedge clk);
      check("fault in reset", f_oe, 1'b0);
      @(posedge clk);
      rst_b <= 1'b1;
      wait_rst_end();
      check("fault after reset", fault_wire, 1'b1);
      $display("reset test done");
      results();
   end
endmodule
